// ### mrx_map.vh
// constants for the move and return execution block
// assumes a 14-bit instruction word and a 13-bit program counter
`ifndef MRX_MAP_VH
`define MRX_MAP_VH
// ==========================================
// opcode patterns (14-bit words)
`define MRX_OP_MOVE_ACC   14'h0080
`define MRX_MASK_MOVE_ACC 14'h3f80
`define MRX_OP_LOAD_LIT   14'h3000
`define MRX_MASK_LOAD_LIT 14'h3f00
`define MRX_OP_RET_LIT    14'h3400
`define MRX_MASK_RET_LIT  14'h3f00
`define MRX_OP_IDLE       14'h0000
`define MRX_OP_RET_IRQ    14'h0009
`define MRX_OP_RETURN     14'h0008
// ==========================================
// fields
`define MRX_GIE_BIT       7
`define MRX_IRQ_CTRL_RST  8'h00
`define MRX_PC_RST        13'h0000
`define MRX_ACC_RST       8'h00
// ==========================================
// cycle counts
`define MRX_CYC_ONE       2'd1
`define MRX_CYC_TWO       2'd2
`define MRX_STACK_DEPTH   8
`endif

// ### mrx_stack.v
// hardware return stack for the execution block
// assumes push and pop never fall in the same cycle
`include "mrx_map.vh"
module mrx_stack (
  // clock and reset
  input  wire        ref_clk,
  input  wire        arst_n,
  // control
  input  wire        push,
  input  wire [12:0] push_addr,
  input  wire        pop,
  // top of stack
  output wire [12:0] stack_top
);
  reg [12:0] mem_q [0:`MRX_STACK_DEPTH-1];
  reg [2:0]  ptr_q;
  integer    i;
  // circular: overflow wraps silently, as in small cores
  assign stack_top = mem_q[ptr_q - 3'd1];
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q <= 3'd0;
      for (i = 0; i < `MRX_STACK_DEPTH; i = i + 1) begin
        mem_q[i] <= 13'h0000;
      end
    end else if (push) begin
      mem_q[ptr_q] <= push_addr;
      ptr_q        <= ptr_q + 3'd1;
    end else if (pop) begin
      ptr_q <= ptr_q - 3'd1;
    end
  end
endmodule

// ### mrx_exec.v
// executes move, load-literal, idle and return instructions
// assumes one instruction word offered per cycle when instr_valid is high
`include "mrx_map.vh"
// Contract
// - move accumulator into file register 0..127
// - load 8-bit literal into accumulator
// - irq return pops stack into pc
// - irq return sets global irq enable
// - irq return takes two cycles
// - literal return loads accumulator
// - literal return loads pc from stack
// - literal return takes two cycles
// - subroutine return pops stack, two cycles
module mrx_exec (
  // clock and reset
  input  wire        ref_clk,
  input  wire        arst_n,
  // instruction in
  input  wire        instr_valid,
  input  wire [13:0] instr_word,
  output wire        instr_ready,
  // call entry from rest of core
  input  wire        call_push,
  input  wire [12:0] call_ret_addr,
  // file register write port
  output reg         file_we_q,
  output reg  [6:0]  file_addr_q,
  output reg  [7:0]  file_wdata_q,
  // architectural state
  output reg  [7:0]  acc_q,
  output reg  [12:0] pc_q,
  output reg  [7:0]  irq_ctrl_q,
  output wire        global_irq_enable,
  output reg         stack_pop_q
);
  // ==========================================
  // sequencer states, one-hot
  localparam S_FETCH = 2'b01;
  localparam S_FLUSH = 2'b10;

  // ==========================================
  // instruction classes, one-hot
  // unknown words fall into the idle class and only advance the pc
  localparam C_IDLE = 6'b000001;
  localparam C_MOVE = 6'b000010;
  localparam C_LOAD = 6'b000100;
  localparam C_RLIT = 6'b001000;
  localparam C_RIRQ = 6'b010000;
  localparam C_RET  = 6'b100000;

  // ==========================================
  // declarations
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [7:0]  acc_d;
  reg  [12:0] pc_d;
  reg  [7:0]  irq_ctrl_d;
  reg         file_we_d;
  reg  [6:0]  file_addr_d;
  reg  [7:0]  file_wdata_d;
  wire [12:0] stack_top;
  wire [5:0]  op_class;
  wire [7:0]  literal;
  wire [6:0]  file_sel;
  wire        take;
  wire        two_cycle;
  wire        is_pop;

  // ==========================================
  // decode helpers
  function match;
    input [13:0] w;
    input [13:0] m;
    input [13:0] p;
    begin
      match = ((w & m) == p);
    end
  endfunction

  // priority order is moot: the patterns never overlap
  function [5:0] classify;
    input [13:0] w;
    begin
      if (match(w, `MRX_MASK_MOVE_ACC, `MRX_OP_MOVE_ACC)) begin
        classify = C_MOVE;
      end else if (match(w, `MRX_MASK_LOAD_LIT, `MRX_OP_LOAD_LIT)) begin
        classify = C_LOAD;
      end else if (match(w, `MRX_MASK_RET_LIT, `MRX_OP_RET_LIT)) begin
        classify = C_RLIT;
      end else if (w == `MRX_OP_RET_IRQ) begin
        classify = C_RIRQ;
      end else if (w == `MRX_OP_RETURN) begin
        classify = C_RET;
      end else begin
        classify = C_IDLE;
      end
    end
  endfunction

  // every word is one program word; only the returns take a second cycle
  function [1:0] cycles_of;
    input [5:0] c;
    begin
      case (c)
        C_RLIT:  cycles_of = `MRX_CYC_TWO;
        C_RIRQ:  cycles_of = `MRX_CYC_TWO;
        C_RET:   cycles_of = `MRX_CYC_TWO;
        default: cycles_of = `MRX_CYC_ONE;
      endcase
    end
  endfunction

  // ==========================================
  // handshake and decode
  // ready drops for the dead cycle of a return, refusing any word offered then
  assign instr_ready       = (state_q == S_FETCH);
  assign take              = instr_valid & instr_ready;
  assign op_class          = classify(instr_word);
  assign literal           = instr_word[7:0];
  assign file_sel          = instr_word[6:0];
  assign two_cycle         = (cycles_of(op_class) == `MRX_CYC_TWO);
  // each two-cycle word here is a return, so length and pop coincide
  assign is_pop            = take & two_cycle;
  assign global_irq_enable = irq_ctrl_q[`MRX_GIE_BIT];

  // ==========================================
  // return stack
  // a call push in the same cycle as a pop would lose the pop
  mrx_stack u_stack (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .push      (call_push),
    .push_addr (call_ret_addr),
    .pop       (is_pop),
    .stack_top (stack_top)
  );

  // ==========================================
  // sequencing
  always @* begin
    state_d = S_FETCH;
    case (state_q)
      S_FETCH: begin
        if (is_pop) begin
          state_d = S_FLUSH;
        end else begin
          state_d = S_FETCH;
        end
      end
      S_FLUSH: begin
        // second cycle of a return: nothing is taken
        state_d = S_FETCH;
      end
      default: begin
        state_d = S_FETCH;
      end
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_FETCH;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================
  // accumulator
  always @* begin
    acc_d = acc_q;
    if (take) begin
      case (op_class)
        C_LOAD:  acc_d = literal;
        C_RLIT:  acc_d = literal;
        default: acc_d = acc_q;
      endcase
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= `MRX_ACC_RST;
    end else begin
      acc_q <= acc_d;
    end
  end

  // ==========================================
  // program counter
  // returns take the stack top as it stood before the pop edge
  always @* begin
    pc_d = pc_q;
    if (take) begin
      case (op_class)
        C_RLIT:  pc_d = stack_top;
        C_RIRQ:  pc_d = stack_top;
        C_RET:   pc_d = stack_top;
        default: pc_d = pc_q + 13'd1;
      endcase
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_q <= `MRX_PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  // ==========================================
  // irq control
  // only the enable bit is owned here; the other bits read as zero
  always @* begin
    irq_ctrl_d = irq_ctrl_q;
    if (take && (op_class == C_RIRQ)) begin
      irq_ctrl_d[`MRX_GIE_BIT] = 1'b1;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ctrl_q <= `MRX_IRQ_CTRL_RST;
    end else begin
      irq_ctrl_q <= irq_ctrl_d;
    end
  end

  // ==========================================
  // file register write port
  // address and data hold after the strobe; only file_we_q marks a write
  always @* begin
    file_we_d    = 1'b0;
    file_addr_d  = file_addr_q;
    file_wdata_d = file_wdata_q;
    if (take && (op_class == C_MOVE)) begin
      file_we_d    = 1'b1;
      file_addr_d  = file_sel;
      file_wdata_d = acc_q;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      file_we_q    <= 1'b0;
      file_addr_q  <= 7'h00;
      file_wdata_q <= 8'h00;
    end else begin
      file_we_q    <= file_we_d;
      file_addr_q  <= file_addr_d;
      file_wdata_q <= file_wdata_d;
    end
  end

  // ==========================================
  // pop strobe, one cycle after a return is taken
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stack_pop_q <= 1'b0;
    end else begin
      stack_pop_q <= is_pop;
    end
  end
endmodule

// ### mrx_exec_assertions.sv
// checker bound onto the move and return execution block
// assumes it sees only the ports of mrx_exec
module mrx_exec_assertions (
  input logic        ref_clk, arst_n, instr_valid, instr_ready,
  input logic        file_we_q, stack_pop_q, global_irq_enable,
  input logic [13:0] instr_word,
  input logic [6:0]  file_addr_q,
  input logic [7:0]  file_wdata_q, acc_q,
  input logic [12:0] pc_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // decode of taken words
  wire       tk = instr_valid & instr_ready;
  wire [7:0] k  = instr_word[7:0];
  wire       mv = tk && (instr_word & 14'h3f80) == 14'h0080;
  wire       ld = tk && instr_word[13:8] == 6'h30;
  wire       rl = tk && instr_word[13:8] == 6'h34;
  wire       ri = tk && instr_word == 14'h0009;
  wire       rs = tk && instr_word == 14'h0008;
  wire       id = tk && instr_word == 14'h0000;
  // ==========================================
  // properties
  property p_mv; mv |=> file_we_q && file_wdata_q == $past(acc_q); endproperty
  a_mv: assert property (p_mv) else $error("move data wrong");
  property p_ad; mv |=> file_addr_q == $past(instr_word[6:0]); endproperty
  a_ad: assert property (p_ad) else $error("move address wrong");
  property p_ld; ld |=> acc_q == $past(k); endproperty
  a_ld: assert property (p_ld) else $error("literal load wrong");
  property p_rl; rl |=> acc_q == $past(k) && stack_pop_q; endproperty
  a_rl: assert property (p_rl) else $error("literal return wrong");
  property p_ri; ri |=> global_irq_enable && stack_pop_q; endproperty
  a_ri: assert property (p_ri) else $error("irq return wrong");
  property p_r2; ri || rl |=> !instr_ready ##1 instr_ready; endproperty
  a_r2: assert property (p_r2) else $error("return length wrong");
  property p_rs; rs |=> stack_pop_q && !instr_ready && $stable(global_irq_enable); endproperty
  a_rs: assert property (p_rs) else $error("plain return wrong");
  property p_id;
    id |=> pc_q == $past(pc_q) + 13'h1 && $stable(acc_q) && !stack_pop_q && !file_we_q;
  endproperty
  a_id: assert property (p_id) else $error("idle changed state");
  property p_rf;
    instr_valid && !instr_ready |=> $stable(acc_q) && $stable(pc_q) && !file_we_q;
  endproperty
  a_rf: assert property (p_rf) else $error("refused word acted on");
endmodule

bind mrx_exec mrx_exec_assertions u_chk (
  .ref_clk           (ref_clk),
  .arst_n            (arst_n),
  .instr_valid       (instr_valid),
  .instr_ready       (instr_ready),
  .file_we_q         (file_we_q),
  .stack_pop_q       (stack_pop_q),
  .global_irq_enable (global_irq_enable),
  .instr_word        (instr_word),
  .file_addr_q       (file_addr_q),
  .file_wdata_q      (file_wdata_q),
  .acc_q             (acc_q),
  .pc_q              (pc_q)
);

// ### testbench.sv
// self-checking bench for the move and return execution block
// assumes registered outputs settle before the falling edge
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 0, arst_n = 0, instr_valid = 0, call_push = 0;
  logic [13:0] instr_word = 14'h0000;
  logic [12:0] call_ret_addr = 13'h0000;
  wire         instr_ready, file_we_q, global_irq_enable, stack_pop_q;
  wire [6:0]   file_addr_q;
  wire [7:0]   file_wdata_q, acc_q, irq_ctrl_q;
  wire [12:0]  pc_q;
  int          bad_count = 0, num_checks = 0;
  always #10 ref_clk = ~ref_clk;
  mrx_exec i_dut (
    .ref_clk           (ref_clk),
    .arst_n            (arst_n),
    .instr_valid       (instr_valid),
    .instr_word        (instr_word),
    .instr_ready       (instr_ready),
    .call_push         (call_push),
    .call_ret_addr     (call_ret_addr),
    .file_we_q         (file_we_q),
    .file_addr_q       (file_addr_q),
    .file_wdata_q      (file_wdata_q),
    .acc_q             (acc_q),
    .pc_q              (pc_q),
    .irq_ctrl_q        (irq_ctrl_q),
    .global_irq_enable (global_irq_enable),
    .stack_pop_q       (stack_pop_q)
  );
  // ==========================================
  // helpers
  task chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task op(input logic [13:0] w);
    @(negedge ref_clk);
    instr_valid = 1'b1;
    instr_word = w;
    @(negedge ref_clk);
    instr_valid = 1'b0;
  endtask
  // two words back to back; the second meets the flush cycle if the first is a return
  task op2(input logic [13:0] w1, input logic [13:0] w2);
    @(negedge ref_clk);
    instr_valid = 1'b1;
    instr_word = w1;
    @(negedge ref_clk);
    instr_word = w2;
    @(negedge ref_clk);
    instr_valid = 1'b0;
  endtask
  task push(input logic [12:0] a);
    @(negedge ref_clk);
    call_push = 1'b1;
    call_ret_addr = a;
    @(negedge ref_clk);
    call_push = 1'b0;
  endtask
  // ==========================================
  // scenarios
  task t_move;
    chk({irq_ctrl_q, acc_q}, 16'h0000);
    chk({instr_ready, pc_q}, 16'h2000);
    op(14'h30a5);
    chk(acc_q, 16'h00a5);
    op(14'h00ff);
    chk({file_we_q, file_addr_q, file_wdata_q}, 16'hffa5);
    op2(14'h3011, 14'h0085);
    chk({file_we_q, file_addr_q, file_wdata_q}, 16'h8511);
    chk({instr_ready, pc_q}, 16'h2004);
  endtask
  task t_ret;
    push(13'h1234);
    op(14'h343c);
    chk({instr_ready, acc_q, stack_pop_q}, 16'h0079);
    chk(pc_q, 16'h1234);
    push(13'h0456);
    op(14'h0009);
    chk({instr_ready, global_irq_enable}, 16'h0001);
    chk(irq_ctrl_q, 16'h0080);
    chk(pc_q, 16'h0456);
    push(13'h0aaa);
    op(14'h0008);
    chk({instr_ready, pc_q}, 16'h0aaa);
    chk({stack_pop_q, global_irq_enable}, 16'h0003);
    op(14'h0000);
    chk({stack_pop_q, file_we_q, acc_q}, 16'h003c);
    chk(pc_q, 16'h0aab);
  endtask
  // nested returns; a word offered in the flush cycle must be ignored
  task t_nest;
    push(13'h0111);
    push(13'h0222);
    op2(14'h0008, 14'h30ee);
    chk({instr_ready, pc_q}, 16'h2222);
    chk(acc_q, 16'h003c);
    op(14'h0009);
    chk({instr_ready, pc_q}, 16'h0111);
  endtask
  // reset in mid-run, then work resumes from reset values
  task t_reset;
    @(negedge ref_clk);
    arst_n = 1'b0;
    @(negedge ref_clk);
    chk({irq_ctrl_q, acc_q}, 16'h0000);
    chk({instr_ready, pc_q}, 16'h2000);
    arst_n = 1'b1;
    op(14'h3077);
    chk(acc_q, 16'h0077);
    chk(pc_q, 16'h0001);
    op(14'h0008);
    chk({instr_ready, pc_q}, 16'h0000);
  endtask
  // ==========================================
  // run control
  initial begin
    repeat (5) @(negedge ref_clk);
    arst_n = 1'b1;
    t_move();
    t_ret();
    t_nest();
    t_reset();
    tally_and_finish();
  end
  // whole run is 41 cycles, so 250 cycles means a hang
  initial begin
    #5000;
    bad_count++;
    tally_and_finish();
  end
  task tally_and_finish;
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
endmodule
